// *** adsp_defines.svh ***
// Contract
// - Chip select high: output floats, inputs ignored
// - Valid select fall resets and realigns port
// - External variant: select filtered over two clocks
// - Internal variant: select filtered about 2 us
// - Valid fall during conversion aborts, keeps result
// - Result register written as final step
// - Valid select low drives prior result MSB
// - Result shifts out MSB first on falls
// - Tenth fall drives output low
// - Select low: MSB returns at completion or 16th fall
// - Four address bits on first four rises
// - Sample from fourth to tenth fall, then hold
// - Shift logic static, no minimum serial rate
// - Port starts on fall, completion or 16th fall
// - Serial and conversion clocks fully unrelated
// - Conversion takes 44 conversion clock cycles
// - Done output low at tenth fall, high when ready
// - Codes 0-A channels, B/C/D mid/low/high references
`ifndef ADSP_DEFINES_SVH
`define ADSP_DEFINES_SVH

`define ADSP_RES_W 10
`define ADSP_ADDR_W 4
`define ADSP_ADDR_RISES 5'd4
`define ADSP_SAMPLE_FALL 5'd4
`define ADSP_HOLD_FALL 5'd10
`define ADSP_LONG_FALL 5'd16
`define ADSP_CONV_CYC 44
`define ADSP_SAR_FIRST 2
`define ADSP_SAR_STEP 4
`define ADSP_CS_EXT_EDGES 2
`define ADSP_CS_FILT_NS 2000
`define ADSP_CLK_PERIOD_NS 10
`define ADSP_CH_LAST 4'ha
`define ADSP_CODE_MID 4'hb
`define ADSP_CODE_LOW 4'hc
`define ADSP_CODE_HIGH 4'hd
`define ADSP_RESULT_RST 10'h000

`endif

// *** adsp_pkg.sv ***
package adsp_pkg;

  typedef enum logic [2:0] {
    ADSP_ST_IDLE = 3'b001,
    ADSP_ST_CONV = 3'b010,
    ADSP_ST_WAIT = 3'b100
  } adsp_state_t;

  typedef enum logic [1:0] {
    ADSP_REF_NONE = 2'h0,
    ADSP_REF_MID = 2'h1,
    ADSP_REF_LOW = 2'h2,
    ADSP_REF_HIGH = 2'h3
  } adsp_ref_t;

endpackage : adsp_pkg

// *** adsp_sync.sv ***
`timescale 1ns/1ps

module adsp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : adsp_sync

// *** adsp_sequencer.sv ***
`timescale 1ns/1ps
`include "adsp_defines.svh"

module adsp_sequencer #(
  parameter bit INT_OSC = 1'b0,
  parameter int CONV_CYC = `ADSP_CONV_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n_pin,
  input wire logic din,
  input wire logic cmp_in,
  output logic dout_o,
  output logic dout_oe,
  output logic eoc,
  output logic sample_en,
  output logic hold,
  output logic [`ADSP_ADDR_W-1:0] ch_sel,
  output adsp_pkg::adsp_ref_t ref_sel,
  output logic [`ADSP_RES_W-1:0] dac_trial
);

  // ********************************************************
  // Constants and checks
  // ********************************************************
  localparam int CS_INT_CYC = (`ADSP_CS_FILT_NS + `ADSP_CLK_PERIOD_NS - 1) / `ADSP_CLK_PERIOD_NS;
  localparam int CS_FILT_CYC = INT_OSC ? CS_INT_CYC : `ADSP_CS_EXT_EDGES;
  localparam int SAR_LAST = `ADSP_SAR_FIRST + (`ADSP_RES_W - 1) * `ADSP_SAR_STEP;
  localparam int CNT_W = $clog2(CONV_CYC + 1);

  if (CONV_CYC < SAR_LAST + 2) begin : g_bad_conv
    $error("CONV_CYC too short for the approximation steps");
  end
  if (CS_FILT_CYC < 1 || CS_FILT_CYC > 255) begin : g_bad_filt
    $error("Select filter count out of range");
  end
  if (`ADSP_RES_W < 2 || `ADSP_RES_W > 15) begin : g_bad_res
    $error("Result width out of range for the bit index");
  end

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [4:0] fall_cnt_r;
  logic [`ADSP_ADDR_W-1:0] addr_r;
  logic ext_r;
  logic fin16_r;
  logic sample_r;
  logic conv_tgl_r;
  logic port_hold_r;
  logic port_rstn;
  logic cs_s;
  logic conv_s;
  logic ext_s;
  logic fin16_s;
  logic conv_prev_r;
  logic conv_start;
  logic smp_s;
  logic smp_prev_r;
  logic smp_start;
  logic [7:0] cs_cnt_r;
  logic cs_hi_r;
  logic cs_hi_nxt;
  logic cs_fall;
  logic restart_go;
  adsp_pkg::adsp_state_t state_r;
  adsp_pkg::adsp_state_t state_nxt;
  logic [CNT_W-1:0] conv_cnt_r;
  logic [3:0] bit_idx_r;
  logic [`ADSP_RES_W-1:0] sar_r;
  logic [`ADSP_RES_W-1:0] result_r;
  logic eoc_r;
  logic [`ADSP_ADDR_W-1:0] ch_sel_r;
  adsp_pkg::adsp_ref_t ref_sel_r;
  logic [3:0] out_idx;
  logic resolve;
  logic conv_end;

  // ********************************************************
  // Serial clock domain
  // ********************************************************
  // Port held in reset while select is high or a restart is issued
  assign port_rstn = rstn & ~port_hold_r;

  // Fall counter, parks at the sixteenth fall
  always_ff @(negedge sclk or negedge port_rstn) begin
    if (!port_rstn) begin
      fall_cnt_r <= 5'd0;
    end else if (fall_cnt_r != `ADSP_LONG_FALL) begin
      fall_cnt_r <= fall_cnt_r + 5'd1;
    end
  end

  // Sample window from fourth to tenth fall
  always_ff @(negedge sclk or negedge port_rstn) begin
    if (!port_rstn) begin
      sample_r <= 1'b0;
    end else if (fall_cnt_r == `ADSP_SAMPLE_FALL - 5'd1) begin
      sample_r <= 1'b1;
    end else if (fall_cnt_r == `ADSP_HOLD_FALL - 5'd1) begin
      sample_r <= 1'b0;
    end
  end

  // Sixteenth fall seen
  always_ff @(negedge sclk or negedge port_rstn) begin
    if (!port_rstn) begin
      fin16_r <= 1'b0;
    end else if (fall_cnt_r == `ADSP_LONG_FALL - 5'd1) begin
      fin16_r <= 1'b1;
    end
  end

  // Hand-off toggle at the tenth fall, reset only by rstn
  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      conv_tgl_r <= 1'b0;
    end else if (fall_cnt_r == `ADSP_HOLD_FALL - 5'd1) begin
      conv_tgl_r <= ~conv_tgl_r;
    end
  end

  // Address capture on the first four rises
  always_ff @(posedge sclk or negedge port_rstn) begin
    if (!port_rstn) begin
      addr_r <= '0;
    end else if (fall_cnt_r < `ADSP_ADDR_RISES) begin
      addr_r <= {addr_r[`ADSP_ADDR_W-2:0], din};
    end
  end

  // Rise after the tenth fall marks a long transfer
  always_ff @(posedge sclk or negedge port_rstn) begin
    if (!port_rstn) begin
      ext_r <= 1'b0;
    end else if (fall_cnt_r >= `ADSP_HOLD_FALL) begin
      ext_r <= 1'b1;
    end
  end

  // Output bit select, low from the tenth fall
  assign out_idx = 4'(`ADSP_RES_W - 1) - fall_cnt_r[3:0];
  assign dout_o = (fall_cnt_r < `ADSP_HOLD_FALL) ? result_r[out_idx] : 1'b0;
  assign sample_en = sample_r;

  // ********************************************************
  // Crossings into the conversion clock domain
  // ********************************************************
  adsp_sync #(
    .WIDTH(4),
    .RST_VAL(4'h8)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({cs_n_pin, conv_tgl_r, ext_r, fin16_r}),
    .q({cs_s, conv_s, ext_s, fin16_s})
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_prev_r <= 1'b0;
    end else begin
      conv_prev_r <= conv_s;
    end
  end

  assign conv_start = conv_s ^ conv_prev_r;

  // Sample window start, address stable from the fourth rise
  adsp_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_sync_smp (
    .clk(clk),
    .rstn(rstn),
    .d(sample_r),
    .q(smp_s)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      smp_prev_r <= 1'b0;
    end else begin
      smp_prev_r <= smp_s;
    end
  end

  assign smp_start = smp_s & ~smp_prev_r;

  // ********************************************************
  // Chip select filter
  // ********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_cnt_r <= 8'h00;
    end else if (cs_s == cs_hi_r || cs_cnt_r == 8'(CS_FILT_CYC - 1)) begin
      cs_cnt_r <= 8'h00;
    end else begin
      cs_cnt_r <= cs_cnt_r + 8'h01;
    end
  end

  always_comb begin
    cs_hi_nxt = cs_hi_r;
    if (cs_s != cs_hi_r && cs_cnt_r == 8'(CS_FILT_CYC - 1)) begin
      cs_hi_nxt = cs_s;
    end
  end

  assign cs_fall = cs_hi_r & ~cs_hi_nxt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_hi_r <= 1'b1;
    end else begin
      cs_hi_r <= cs_hi_nxt;
    end
  end

  assign dout_oe = ~cs_hi_r;

  // ********************************************************
  // Conversion sequencer
  // ********************************************************
  assign conv_end = (conv_cnt_r == CNT_W'(CONV_CYC - 1));
  assign restart_go = (state_r == adsp_pkg::ADSP_ST_WAIT) && !cs_fall && (!ext_s || fin16_s);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      adsp_pkg::ADSP_ST_IDLE: begin
        if (conv_start) begin
          state_nxt = adsp_pkg::ADSP_ST_CONV;
        end
      end
      adsp_pkg::ADSP_ST_CONV: begin
        if (cs_fall) begin
          state_nxt = adsp_pkg::ADSP_ST_IDLE;
        end else if (conv_end) begin
          state_nxt = cs_hi_r ? adsp_pkg::ADSP_ST_IDLE : adsp_pkg::ADSP_ST_WAIT;
        end
      end
      adsp_pkg::ADSP_ST_WAIT: begin
        if (cs_fall || restart_go) begin
          state_nxt = adsp_pkg::ADSP_ST_IDLE;
        end
      end
      default: begin
        state_nxt = adsp_pkg::ADSP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= adsp_pkg::ADSP_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Port hold: select high or restart pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_hold_r <= 1'b1;
    end else begin
      port_hold_r <= cs_hi_nxt | restart_go;
    end
  end

  // Cycle counter over the whole conversion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_cnt_r <= '0;
    end else if (state_r != adsp_pkg::ADSP_ST_CONV) begin
      conv_cnt_r <= '0;
    end else if (!conv_end) begin
      conv_cnt_r <= conv_cnt_r + CNT_W'(1);
    end
  end

  // Approximation: one bit per step
  assign resolve = (state_r == adsp_pkg::ADSP_ST_CONV) && (conv_cnt_r >= CNT_W'(`ADSP_SAR_FIRST))
    && (conv_cnt_r <= CNT_W'(SAR_LAST))
    && ((conv_cnt_r - CNT_W'(`ADSP_SAR_FIRST)) % CNT_W'(`ADSP_SAR_STEP) == '0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sar_r <= '0;
      bit_idx_r <= 4'h0;
    end else if (conv_start && state_r == adsp_pkg::ADSP_ST_IDLE) begin
      sar_r <= '0;
      bit_idx_r <= 4'(`ADSP_RES_W - 1);
    end else if (resolve) begin
      sar_r[bit_idx_r] <= cmp_in;
      bit_idx_r <= bit_idx_r - 4'h1;
    end
  end

  assign dac_trial = (state_r == adsp_pkg::ADSP_ST_CONV) ?
    (sar_r | (`ADSP_RES_W'(1) << bit_idx_r)) : sar_r;

  // Result written only at the last cycle, never on abort
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_r <= `ADSP_RESULT_RST;
    end else if (state_r == adsp_pkg::ADSP_ST_CONV && conv_end && !cs_fall) begin
      result_r <= sar_r;
    end
  end

  // Done flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eoc_r <= 1'b1;
    end else if (conv_start) begin
      eoc_r <= 1'b0;
    end else if (state_r == adsp_pkg::ADSP_ST_CONV && state_nxt != adsp_pkg::ADSP_ST_CONV) begin
      eoc_r <= 1'b1;
    end
  end

  assign eoc = eoc_r;
  assign hold = (state_r == adsp_pkg::ADSP_ST_CONV);

  // Channel and reference selection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch_sel_r <= '0;
      ref_sel_r <= adsp_pkg::ADSP_REF_NONE;
    end else if (smp_start || conv_start) begin
      ch_sel_r <= addr_r;
      case (addr_r)
        `ADSP_CODE_MID: ref_sel_r <= adsp_pkg::ADSP_REF_MID;
        `ADSP_CODE_LOW: ref_sel_r <= adsp_pkg::ADSP_REF_LOW;
        `ADSP_CODE_HIGH: ref_sel_r <= adsp_pkg::ADSP_REF_HIGH;
        default: ref_sel_r <= adsp_pkg::ADSP_REF_NONE;
      endcase
    end
  end

  assign ch_sel = ch_sel_r;
  assign ref_sel = ref_sel_r;

endmodule : adsp_sequencer

// *** adsp_sequencer_asserts.sv ***
`timescale 1ns/1ps
// ****
// Checker
// ****
module adsp_sequencer_asserts #(
  parameter int CONV_CYC = 44
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n_pin,
  input wire logic din,
  input wire logic cmp_in,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic eoc,
  input wire logic sample_en,
  input wire logic hold,
  input wire logic [3:0] ch_sel,
  input wire adsp_pkg::adsp_ref_t ref_sel,
  input wire logic [9:0] dac_trial
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= hold ? cnt_r + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence sel_hi;
    cs_n_pin [*8];
  endsequence
  sequence sel_lo;
    !cs_n_pin [*8];
  endsequence
  AST_SEL_FLOAT: assert property (sel_hi |-> !dout_oe) else $error("driven while deselected");
  AST_SEL_ON: assert property (sel_lo |-> dout_oe) else $error("select low not taken");
  AST_SEL_FILT: assert property ($rose(dout_oe) |-> !$past(cs_n_pin, 2) && !$past(cs_n_pin, 3))
    else $error("select glitch taken");
  AST_EOC_LOW: assert property ($rose(hold) |-> ##[0:2] !eoc) else $error("done high in conversion");
  AST_CONV_LEN: assert property ($fell(hold) && $past(dout_oe, 8) |->
    $past(cnt_r) >= CONV_CYC - 2 && $past(cnt_r) <= CONV_CYC + 1) else $error("conversion length");
  AST_SAMPLE_HOLD: assert property (!(sample_en && hold)) else $error("sample during hold");
  AST_DOUT_HOLD: assert property (hold && dout_oe |-> !dout_o) else $error("output not low");
  AST_REF_HIGH: assert property ((ch_sel == 4'hd) [*8] |-> ref_sel == adsp_pkg::ADSP_REF_HIGH)
    else $error("reference select");
endmodule : adsp_sequencer_asserts

bind adsp_sequencer adsp_sequencer_asserts #(.CONV_CYC(CONV_CYC)) u_chk (.clk(clk), .rstn(rstn),
  .sclk(sclk), .cs_n_pin(cs_n_pin), .din(din), .cmp_in(cmp_in), .dout_o(dout_o), .dout_oe(dout_oe),
  .eoc(eoc), .sample_en(sample_en), .hold(hold), .ch_sel(ch_sel), .ref_sel(ref_sel), .dac_trial(dac_trial));

// *** adsp_host_model.sv ***
`timescale 1ns/1ps
// ****
// Host serial master
// ****
module adsp_host_model (
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  task automatic sel(input logic v);
    cs_n = v;
  endtask : sel
  task automatic xfer(input logic [3:0] addr, input int n, input bit keep, output logic [15:0] rd);
    int i;
    int w;
    rd = 16'h0000;
    w = 0;
    if (cs_n) begin
      cs_n = 1'b0;
      while (dout_oe !== 1'b1 && w < 200) begin
        #10;
        w++;
      end
      #100;
    end
    for (i = 0; i < n; i++) begin
      din = (i < 4) ? addr[3 - i] : ~din;
      #62.5 sclk = 1'b1;
      #62.5 rd[15 - i] = dout;
      sclk = 1'b0;
    end
    din = ~din;
    if (!keep) begin
      #60 cs_n = 1'b1;
    end
  endtask : xfer
endmodule : adsp_host_model

// *** test_adsp_sequencer.sv ***
`timescale 1ns/1ps
// ****
// Testbench
// ****
module test_adsp_sequencer;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmp_in = 1'b0;
  wire logic cs_n;
  wire logic sclk;
  wire logic din;
  logic dout_o, dout_oe, eoc, sample_en, hold;
  logic [3:0] ch_sel;
  logic [9:0] dac_trial;
  adsp_pkg::adsp_ref_t ref_sel;
  logic [15:0] rd;
  int errors = 0;
  int checks = 0;
  always #5 clk = ~clk;
  adsp_sequencer #(.INT_OSC(1'b0), .CONV_CYC(44)) DUT (.clk(clk), .rstn(rstn), .sclk(sclk),
    .cs_n_pin(cs_n), .din(din), .cmp_in(cmp_in), .dout_o(dout_o), .dout_oe(dout_oe), .eoc(eoc),
    .sample_en(sample_en), .hold(hold), .ch_sel(ch_sel), .ref_sel(ref_sel), .dac_trial(dac_trial));
  adsp_host_model host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_o), .dout_oe(dout_oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_eoc;
    int w;
    w = 0;
    while (eoc !== 1'b1 && w < 300) begin
      @(negedge clk);
      w++;
    end
    chk(16'(eoc), 16'h0001);
  endtask : wait_eoc
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic t_first;
    cmp_in = 1'b1;
    host.xfer(4'hd, 16, 1'b1, rd);
    chk(rd, 16'h0000);
    chk(16'(ch_sel), 16'h000d);
    chk({14'h0, ref_sel}, 16'h0003);
    chk(16'(sample_en), 16'h0000);
    wait_eoc();
    chk({6'h0, dac_trial}, 16'h03ff);
    repeat (4) @(negedge clk);
    chk({14'h0, dout_oe, dout_o}, 16'h0003);
    $display("first transfer done");
  endtask : t_first
  task automatic t_cont;
    cmp_in = 1'b0;
    host.xfer(4'h5, 10, 1'b0, rd);
    chk(rd, 16'hffc0);
    repeat (6) @(negedge clk);
    chk({14'h0, eoc, hold}, 16'h0001);
    chk(16'(ch_sel), 16'h0005);
    wait_eoc();
    $display("continued transfer done");
  endtask : t_cont
  task automatic t_abort;
    cmp_in = 1'b1;
    host.xfer(4'hb, 10, 1'b0, rd);
    chk(rd, 16'h0000);
    chk({14'h0, ref_sel}, 16'h0001);
    repeat (16) @(negedge clk);
    chk(16'(hold), 16'h0001);
    host.sel(1'b0);
    repeat (12) @(negedge clk);
    chk({14'h0, eoc, hold}, 16'h0002);
    host.xfer(4'h0, 12, 1'b0, rd);
    chk(rd, 16'h0000);
    wait_eoc();
    $display("abort done");
  endtask : t_abort
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk({13'h0, dout_oe, eoc, hold}, 16'h0002);
    t_first();
    t_cont();
    t_abort();
    final_report();
  end
  initial begin
    #100000;
    errors++;
    final_report();
  end
endmodule : test_adsp_sequencer
